// File: rtl/ppc_top.sv
`include "ppc_cfg.svh"
// Notes on behaviour
// R01 - Pulls on out of reset only on A0, A2, B5
// R02 - Pull enable writable for every pin
// R03 - Pull direction fixed, debug clock pulls down
// R04 - Pull enable reset set A0, A2, B5
// R05 - Mux reset function three on A0, A2, B5
// R06 - Interrupts only on listed A and B pins
// R07 - Slew fixed, off A2 A6 A7 B0
// R08 - High drive only A12 A13 B0 B1
// R09 - Passive filter reset pin and B5 only
// R10 - Two-wire bus mux forces open drain, except on A1
// R11 - UART transmit open drain by option bit
// R12 - Direct single cycle port at high base
// R13 - Crossbar and alias bases reach registers
// R14 - Full atomic operations use alias slot
// R15 - No lock, config always writable
module ppc_top
  import ppc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        PCW_WR,
  input  wire logic        PCW_PORT,
  input  wire logic [4:0]  PCW_PIN,
  input  wire logic        PCW_PULL,
  input  wire ppc_mux_t    PCW_MUX,
  input  wire logic        PCW_DSE,
  input  wire logic        PCW_PFE,
  input  wire logic        PCW_RD,
  output logic             PCW_RD_PULL,
  output logic             PCW_RD_PULL_UP,
  output logic             PCW_RD_SRE,
  output logic             PCW_RD_DSE,
  output logic             PCW_RD_PFE,
  output logic             PCW_RD_IRQC,
  output ppc_mux_t         PCW_RD_MUX,
  input  wire logic        UART_OPEN_DRAIN_EN,
  input  wire logic        RESET_PIN_PFE_EN,
  input  wire logic [31:0] PIN_IRQ_IN_A,
  input  wire logic [31:0] PIN_IRQ_IN_B,
  output logic [31:0]      PULL_EN_A,
  output logic [31:0]      PULL_EN_B,
  output logic [31:0]      PULL_UP_A,
  output logic [31:0]      PULL_UP_B,
  output logic [31:0]      SLEW_EN_A,
  output logic [31:0]      SLEW_EN_B,
  output logic [31:0]      HIGH_DRIVE_A,
  output logic [31:0]      HIGH_DRIVE_B,
  output logic             PFE_B5,
  output logic             PFE_RESET_PIN,
  output logic [31:0]      OPEN_DRAIN_A,
  output logic [31:0]      OPEN_DRAIN_B,
  output logic             PORT_IRQ_A,
  output logic             PORT_IRQ_B,
  input  wire logic        CORE_VALID,
  input  wire logic [31:0] CORE_ADDR,
  output logic             CORE_READY,
  output logic             CORE_ALIAS,
  output logic             CORE_FULL_ATOMIC,
  output logic [11:0]      CORE_OFFSET
);
  // Index 0 is port A, index 1 is port B
  localparam logic [31:0] PULL_RST [2] = '{`PPC_PULL_RST_A,
                                           `PPC_PULL_RST_B};
  localparam logic [31:0] FN3_MSK [2]  = '{`PPC_FN3_RST_A,
                                           `PPC_FN3_RST_B};

  logic [31:0] pull_a, pull_b;
  ppc_mux_t    mux_a [32];
  ppc_mux_t    mux_b [32];
  logic        dse_reg [4];
  logic        pfe_reg;
  logic        pfe_rst_reg;
  logic [31:0] sel_a, sel_b;

  // Write strobes per pin; no lock, so a write always lands
  assign sel_a = (PCW_WR && !PCW_PORT) ? (32'h1 << PCW_PIN) : 32'h0; // R15
  assign sel_b = (PCW_WR &&  PCW_PORT) ? (32'h1 << PCW_PIN) : 32'h0; // R15

  genvar g;
  generate
    for (g = 0; g < `PPC_NPIN; g++) begin : g_pin
      ppc_pin #(
        .PULL_RST (PULL_RST[0][g]),                                // R04
        .MUX_RST  (FN3_MSK[0][g] ? `PPC_MUX_FN3 : `PPC_MUX_FN0)    // R05
      ) u_a (
        .clk     (CLK),
        .nrst    (NRST),
        .wr      (sel_a[g]),                                       // R02
        .pull_in (PCW_PULL),
        .mux_in  (PCW_MUX),
        .pull    (pull_a[g]),
        .mux     (mux_a[g])
      );
      ppc_pin #(
        .PULL_RST (PULL_RST[1][g]),                                // R04
        .MUX_RST  (FN3_MSK[1][g] ? `PPC_MUX_FN3 : `PPC_MUX_FN0)    // R05
      ) u_b (
        .clk     (CLK),
        .nrst    (NRST),
        .wr      (sel_b[g]),                                       // R02
        .pull_in (PCW_PULL),
        .mux_in  (PCW_MUX),
        .pull    (pull_b[g]),
        .mux     (mux_b[g])
      );
      // Transmit pin shares code 2 with the two-wire bus, so there code 2 gives
      // open drain only with the option bit set; elsewhere the bus forces open drain
      assign OPEN_DRAIN_A[g] = (g == `PPC_UART_TX_PIN) ?
        (UART_OPEN_DRAIN_EN && mux_a[g] == `PPC_MUX_UART) :        // R11
        (mux_a[g] == `PPC_MUX_I2C);                                // R10
      assign OPEN_DRAIN_B[g] = (mux_b[g] == `PPC_MUX_I2C);          // R10
    end
  endgenerate

  // Pull enables come straight from the pin registers, A0 A2 B5 on out of reset
  assign PULL_EN_A = pull_a;                                        // R01
  assign PULL_EN_B = pull_b;                                        // R01
  assign PULL_UP_A = `PPC_PULL_UP_A;                                // R03
  assign PULL_UP_B = `PPC_PULL_UP_B;                                // R03
  assign SLEW_EN_A = `PPC_SRE_RST_A;                                // R07
  assign SLEW_EN_B = `PPC_SRE_RST_B;                                // R07

  wire dse_wr_a = PCW_WR && !PCW_PORT && (PCW_PIN == 5'd12 ||
                  PCW_PIN == 5'd13);
  wire dse_wr_b = PCW_WR && PCW_PORT && (PCW_PIN == 5'd0 ||
                  PCW_PIN == 5'd1);
  wire [1:0] dse_idx = {PCW_PORT, PCW_PIN[0]};

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      dse_reg     <= '{default: 1'b0};                              // R08
      pfe_reg     <= 1'b0;                                          // R09
      pfe_rst_reg <= 1'b1;                                          // R09
    end else begin
      if (dse_wr_a || dse_wr_b)
        dse_reg[dse_idx] <= PCW_DSE;                                // R08
      if (PCW_WR && PCW_PORT && PCW_PIN == 5'd5)
        pfe_reg <= PCW_PFE;                                         // R09
      pfe_rst_reg <= RESET_PIN_PFE_EN;
    end
  end

  assign HIGH_DRIVE_A = {18'h0, dse_reg[1], dse_reg[0], 12'h0};     // R08
  assign HIGH_DRIVE_B = {30'h0, dse_reg[3], dse_reg[2]};            // R08
  assign PFE_B5       = pfe_reg;                                    // R09
  assign PFE_RESET_PIN = pfe_rst_reg;                               // R09

  // Unsupported pins are masked so stray inputs never raise a request
  assign PORT_IRQ_A = |(PIN_IRQ_IN_A & `PPC_IRQ_CAP_A);             // R06
  assign PORT_IRQ_B = |(PIN_IRQ_IN_B & `PPC_IRQ_CAP_B);             // R06

  wire [31:0] rd_pup  = PCW_PORT ? `PPC_PULL_UP_B : `PPC_PULL_UP_A;
  wire [31:0] rd_sre  = PCW_PORT ? `PPC_SRE_RST_B : `PPC_SRE_RST_A;
  wire [31:0] rd_irq  = PCW_PORT ? `PPC_IRQ_CAP_B : `PPC_IRQ_CAP_A;
  wire [31:0] rd_pull = PCW_PORT ? pull_b : pull_a;
  wire [31:0] rd_dse = PCW_PORT ? HIGH_DRIVE_B : HIGH_DRIVE_A;
  wire        rd_pfe = PCW_PORT && PCW_PIN == 5'd5 && pfe_reg;
  wire ppc_mux_t rd_mux = PCW_PORT ? mux_b[PCW_PIN] : mux_a[PCW_PIN];

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      PCW_RD_PULL    <= 1'b0;
      PCW_RD_PULL_UP <= 1'b0;
      PCW_RD_SRE  <= 1'b0;
      PCW_RD_DSE  <= 1'b0;
      PCW_RD_PFE  <= 1'b0;
      PCW_RD_IRQC <= 1'b0;
      PCW_RD_MUX  <= `PPC_MUX_FN0;
    end else if (PCW_RD) begin
      PCW_RD_PULL    <= rd_pull[PCW_PIN];
      PCW_RD_PULL_UP <= rd_pup[PCW_PIN];                            // R03
      PCW_RD_SRE  <= rd_sre[PCW_PIN];
      PCW_RD_DSE  <= rd_dse[PCW_PIN];
      PCW_RD_PFE  <= rd_pfe;
      PCW_RD_IRQC <= rd_irq[PCW_PIN];
      PCW_RD_MUX  <= rd_mux;
    end
  end

  // Address decode: three windows, all onto the same registers
  wire hit_io    = (CORE_ADDR & `PPC_IO_MASK) == `PPC_IO_BASE;      // R12
  wire hit_xbar  = (CORE_ADDR & `PPC_WIN_MASK) == `PPC_XBAR_BASE;   // R13
  wire hit_alias = (CORE_ADDR & `PPC_WIN_MASK) == `PPC_ALIAS_BASE;  // R13
  ppc_win_t win;
  assign win = hit_io ? PPC_WIN_IO : hit_xbar ? PPC_WIN_XBAR :
               hit_alias ? PPC_WIN_ALIAS : PPC_WIN_NONE;

  // Zero wait states: ready in the request cycle
  assign CORE_READY       = CORE_VALID && win != PPC_WIN_NONE;      // R12
  assign CORE_ALIAS       = CORE_VALID && win == PPC_WIN_ALIAS;
  assign CORE_FULL_ATOMIC = CORE_VALID && win == PPC_WIN_ALIAS;     // R14
  assign CORE_OFFSET      = CORE_ADDR[11:0];                        // R13

  property p_pull_dir;
    @(posedge CLK) PULL_UP_A[0] == 1'b0 && PULL_UP_B[0] == 1'b1;
  endproperty
  a_pull_dir: assert property (p_pull_dir)                          // R03
    else $error("pull direction not fixed");
  property p_pull_rst;
    @(posedge CLK) $rose(NRST) |-> PULL_EN_A[0] && PULL_EN_A[2] &&
      PULL_EN_B[5] && !PULL_EN_A[1] && PCW_RD_MUX == `PPC_MUX_FN0;
  endproperty
  a_pull_rst: assert property (p_pull_rst)                          // R04
    else $error("pull enable reset wrong");
  sequence s_wr_a;
    PCW_WR && !PCW_PORT;
  endsequence
  property p_wr;
    @(posedge CLK) disable iff (!NRST)
      s_wr_a |=> PULL_EN_A[$past(PCW_PIN)] == $past(PCW_PULL);
  endproperty
  a_wr: assert property (p_wr)                                      // R02
    else $error("pull enable write lost");
  property p_irq;
    @(posedge CLK) PIN_IRQ_IN_A[2] && !(|(PIN_IRQ_IN_A & ~32'h4))
      |-> !PORT_IRQ_A;
  endproperty
  a_irq: assert property (p_irq)                                    // R06
    else $error("unsupported pin raised irq");
  property p_od;
    @(posedge CLK) disable iff (!NRST)
      mux_b[3] == `PPC_MUX_I2C |-> OPEN_DRAIN_B[3];
  endproperty
  a_od: assert property (p_od)                                      // R10
    else $error("i2c pin not open drain");
  property p_uart;
    @(posedge CLK) !UART_OPEN_DRAIN_EN |-> !OPEN_DRAIN_A[1];
  endproperty
  a_uart: assert property (p_uart)                                  // R11
    else $error("uart tx open drain without option");
  property p_ready;
    @(posedge CLK) CORE_VALID && CORE_ADDR[31:27] == 5'h1f |-> CORE_READY;
  endproperty
  a_ready: assert property (p_ready)                                // R12
    else $error("io port not single cycle");
  property p_dse;
    @(posedge CLK) HIGH_DRIVE_A[11:0] == 12'h0 &&
      HIGH_DRIVE_B[31:2] == 30'h0;
  endproperty
  a_dse: assert property (p_dse)                                    // R08
    else $error("high drive on wrong pin");
endmodule : ppc_top

// File: rtl/ppc_cfg.svh
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
`define PPC_NPIN        32
`define PPC_MUXW        3
`define PPC_PULL_RST_A  32'h0000_0005
`define PPC_PULL_RST_B  32'h0000_0020
`define PPC_FN3_RST_A   32'h0000_0005
`define PPC_FN3_RST_B   32'h0000_0020
`define PPC_PULL_UP_A   32'hffff_fffe
`define PPC_PULL_UP_B   32'hffff_ffff
`define PPC_SRE_RST_A   32'hffff_ff3b
`define PPC_SRE_RST_B   32'hffff_fffe
`define PPC_DSE_CAP_A   32'h0000_3000
`define PPC_DSE_CAP_B   32'h0000_0003
`define PPC_IRQ_CAP_A   32'h0000_1c83
`define PPC_IRQ_CAP_B   32'h0000_00ff
`define PPC_PFE_CAP_B   32'h0000_0020
`define PPC_MUX_FN3     3'h3
`define PPC_MUX_FN0     3'h0
`define PPC_MUX_I2C     3'h2
`define PPC_MUX_UART    3'h2
`define PPC_UART_TX_PIN 5'h01
`define PPC_IO_BASE     32'hf800_0000
`define PPC_XBAR_BASE   32'h400f_f000
`define PPC_ALIAS_BASE  32'h4000_f000
`define PPC_WIN_MASK    32'hffff_f000
`define PPC_IO_MASK     32'hf800_0000
`define PPC_ALIAS_SLOT  4'hf
`endif

// File: rtl/ppc_pkg.sv
`include "ppc_cfg.svh"
package ppc_pkg;
  typedef logic [`PPC_MUXW-1:0] ppc_mux_t;
  typedef enum logic [1:0] {PPC_WIN_NONE, PPC_WIN_IO, PPC_WIN_XBAR,
                            PPC_WIN_ALIAS} ppc_win_t;
endpackage : ppc_pkg

// File: rtl/ppc_pin.sv
`include "ppc_cfg.svh"
module ppc_pin
  import ppc_pkg::*;
#(
  parameter logic     PULL_RST = 1'b0,
  parameter ppc_mux_t MUX_RST  = `PPC_MUX_FN0
) (
  input  wire logic     clk,
  input  wire logic     nrst,
  input  wire logic     wr,
  input  wire logic     pull_in,
  input  wire ppc_mux_t mux_in,
  output logic          pull,
  output ppc_mux_t      mux
);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pull <= PULL_RST;
      mux  <= MUX_RST;
    end else if (wr) begin
      pull <= pull_in;
      mux  <= mux_in;
    end
  end
endmodule : ppc_pin

// File: bench/ppc_core_model.sv
module ppc_core_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [31:0] req_addr,
  output logic             valid = 1'b0,
  output logic [31:0]      addr = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Full atomic work is aimed at the alias slot, the bridge slot is a subset
  // Idle address toggles so a stale decode cannot match by luck
  always @(posedge clk) begin
    valid <= req;
    addr  <= req ? req_addr : ~addr;
  end
endmodule : ppc_core_model

// File: bench/ppc_top_tb.sv
module ppc_top_tb import ppc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic p; logic [4:0] n; logic e; ppc_mux_t m; logic d;
    logic [31:0] pa, pb, ha, hb, ob;} ppc_row_t;
  localparam logic [63:0] PUP = {32'hffff_ffff, 32'hffff_fffe};
  localparam logic [63:0] SR = {32'hffff_fffe, 32'hffff_ff3b};
  localparam logic [63:0] IQ = {32'h0000_00ff, 32'h0000_1c83};
  localparam logic [63:0] PLR = {32'h0000_0020, 32'h0000_0005};
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, port = 1'b0, pull = 1'b0;
  logic dse = 1'b0, pfe = 1'b0, rd = 1'b0, uod = 1'b0, rpf = 1'b1;
  logic req = 1'b0, cv, r_pull, r_pup, r_sre, r_dse, r_pfe, r_irq, pfb5, pfr;
  logic iqa, iqb, rdy, als, fat;
  logic [4:0] pin = 5'h0;
  ppc_mux_t mux = 3'h0, r_mux;
  logic [31:0] ia = 32'h0, ib = 32'h0, raddr = 32'h0, ca, pea, peb, pua;
  logic [31:0] pub, sla, slb, hda, hdb, oda, odb;
  logic [11:0] ofs;
  int miscompares = 0, checks_done = 0, cycles = 0;
  logic [31:0] cad [5] = '{32'hffff_fffc, 32'h400f_f004, 32'h4000_f008,
                           32'h400e_f000, 32'h4001_0000};
  logic [2:0] cex [5] = '{3'h4, 3'h4, 3'h7, 3'h0, 3'h0};
  ppc_row_t rows [6] = '{
    '{1'b0, 5'h01, 1'b1, 3'h0, 1'b1, 32'h7, 32'h20, 32'h0, 32'h0, 32'h0},
    '{1'b0, 5'h0c, 1'b1, 3'h0, 1'b1, 32'h1007, 32'h20, 32'h1000, 32'h0, 32'h0},
    '{1'b1, 5'h01, 1'b0, 3'h0, 1'b1, 32'h1007, 32'h20, 32'h1000, 32'h2, 32'h0},
    '{1'b1, 5'h03, 1'b1, 3'h2, 1'b0, 32'h1007, 32'h28, 32'h1000, 32'h2, 32'h8},
    '{1'b0, 5'h00, 1'b0, 3'h0, 1'b0, 32'h1006, 32'h28, 32'h1000, 32'h2, 32'h8},
    '{1'b0, 5'h0c, 1'b1, 3'h0, 1'b0, 32'h1006, 32'h28, 32'h0, 32'h2, 32'h8}};
  ppc_top dut_u (.CLK(clk), .NRST(nrst), .PCW_WR(wr), .PCW_PORT(port),
    .PCW_PIN(pin), .PCW_PULL(pull), .PCW_MUX(mux), .PCW_DSE(dse),
    .PCW_PFE(pfe), .PCW_RD(rd), .PCW_RD_PULL(r_pull),
    .PCW_RD_PULL_UP(r_pup), .PCW_RD_SRE(r_sre),
    .PCW_RD_DSE(r_dse), .PCW_RD_PFE(r_pfe), .PCW_RD_IRQC(r_irq),
    .PCW_RD_MUX(r_mux), .UART_OPEN_DRAIN_EN(uod), .RESET_PIN_PFE_EN(rpf),
    .PIN_IRQ_IN_A(ia), .PIN_IRQ_IN_B(ib), .PULL_EN_A(pea), .PULL_EN_B(peb),
    .PULL_UP_A(pua), .PULL_UP_B(pub), .SLEW_EN_A(sla), .SLEW_EN_B(slb),
    .HIGH_DRIVE_A(hda), .HIGH_DRIVE_B(hdb), .PFE_B5(pfb5),
    .PFE_RESET_PIN(pfr), .OPEN_DRAIN_A(oda), .OPEN_DRAIN_B(odb),
    .PORT_IRQ_A(iqa), .PORT_IRQ_B(iqb), .CORE_VALID(cv), .CORE_ADDR(ca),
    .CORE_READY(rdy), .CORE_ALIAS(als), .CORE_FULL_ATOMIC(fat),
    .CORE_OFFSET(ofs));
  ppc_core_model core_u (.clk(clk), .req(req), .req_addr(raddr),
    .valid(cv), .addr(ca));
  always #25 clk = ~clk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      $display("wrong value %s exp %h got %h", n, e, s);
      miscompares++;
    end
  endtask : chk
  task automatic wpin(logic p, logic [4:0] n, logic e, ppc_mux_t m, logic d,
                      logic f);
    @(posedge clk);
    port <= p;
    pin <= n;
    pull <= e;
    mux <= m;
    dse <= d;
    pfe <= f;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wpin
  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // Ceiling well above the roughly 170 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk("pea", 32'h5, pea);
    chk("peb", 32'h20, peb);
    chk("pua", PUP[31:0], pua);
    chk("pub", PUP[63:32], pub);
    chk("sla", SR[31:0], sla);
    chk("slb", SR[63:32], slb);
    chk("hd", 32'h0, hda | hdb);
    chk("pf", 32'h1, {pfb5, pfr});
    chk("od", 32'h0, oda | odb);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      port <= i[5];
      pin <= i[4:0];
      rd <= 1'b1;
      ia <= 32'h1 << i[4:0];
      ib <= 32'h1 << i[4:0];
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rpup", PUP[i], r_pup);
      chk("rsre", SR[i], r_sre);
      chk("rirq", IQ[i], r_irq);
      chk("irqa", IQ[i[4:0]], iqa);
      chk("irqb", IQ[32 + i[4:0]], iqb);
      chk("rpull", PLR[i], r_pull);
      chk("rdse", 32'h0, r_dse);
      chk("rmux", (i == 0 || i == 2 || i == 37) ? 3'h3 : 3'h0, r_mux);
    end
    foreach (rows[k]) begin
      wpin(rows[k].p, rows[k].n, rows[k].e, rows[k].m, rows[k].d, 1'b0);
      chk("pea", rows[k].pa, pea);
      chk("peb", rows[k].pb, peb);
      chk("hda", rows[k].ha, hda);
      chk("hdb", rows[k].hb, hdb);
      chk("odb", rows[k].ob, odb);
    end
    wpin(1'b0, 5'h01, 1'b1, 3'h2, 1'b0, 1'b0);
    chk("oda", 32'h0, oda);
    @(posedge clk);
    uod <= 1'b1;
    rpf <= 1'b0;
    wpin(1'b0, 5'h03, 1'b0, 3'h0, 1'b0, 1'b1);
    chk("oda", 32'h2, oda);
    chk("pf", 32'h0, {pfb5, pfr});
    wpin(1'b1, 5'h05, 1'b1, 3'h3, 1'b0, 1'b1);
    chk("pfb", 32'h1, pfb5);
    @(posedge clk);
    port <= 1'b1;
    pin <= 5'h05;
    rd <= 1'b1;
    @(posedge clk);
    pin <= 5'h01;
    #1;
    chk("rpfe", 32'h1, r_pfe);
    chk("rmux", 32'h3, r_mux);
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdse", 32'h1, r_dse);
    chk("rpull", 32'h0, r_pull);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      req <= 1'b1;
      raddr <= cad[i];
      @(posedge clk);
      #1;
      chk("core", cex[i], {rdy, als, fat});
      chk("ofs", cad[i][11:0], ofs);
    end
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("idle", 32'h0, rdy);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("pfr", 32'h1, pfr);
    @(posedge clk);
    #1;
    chk("pea", 32'h5, pea);
    chk("hd", 32'h0, hda | hdb);
    chk("od", 32'h0, oda | odb);
    chk("pf", 32'h0, {pfb5, pfr});
    end_of_test();
  end
endmodule : ppc_top_tb
